//--- inc/mev_pkg.sv
// constants of the motion event detect and configuration block
// assumes a 250 MHz core clock and an 8-bit register port decoded upstream
package mev_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [5:0] MEV_OFS_SHOCK_THR = 6'h1d;
   localparam logic [5:0] MEV_OFS_X_TRIM = 6'h1e;
   localparam logic [5:0] MEV_OFS_Y_TRIM = 6'h1f;
   localparam logic [5:0] MEV_OFS_Z_TRIM = 6'h20;
   localparam logic [5:0] MEV_OFS_DUR = 6'h21;
   localparam logic [5:0] MEV_OFS_WAIT = 6'h22;
   localparam logic [5:0] MEV_OFS_WINDOW = 6'h23;
   localparam logic [5:0] MEV_OFS_MOT_THR = 6'h24;
   localparam logic [5:0] MEV_OFS_STILL_THR = 6'h25;
   localparam logic [5:0] MEV_OFS_STILL_TIME = 6'h26;
   localparam logic [5:0] MEV_OFS_COUPLING = 6'h27;
   localparam logic [5:0] MEV_OFS_SHOCK_AXES = 6'h2a;
   localparam logic [5:0] MEV_OFS_SOURCE = 6'h2b;
   localparam logic [5:0] MEV_OFS_RATE = 6'h2c;
   localparam logic [5:0] MEV_OFS_EVT_FLAGS = 6'h30;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int MEV_CPL_ACT_AC = 7;
   localparam int MEV_CPL_ACT_AX = 4;
   localparam int MEV_CPL_INA_AC = 3;
   localparam int MEV_CPL_INA_AX = 0;
   localparam int MEV_SHK_SUPPRESS = 3;
   localparam int MEV_SRC_ACT = 4;
   localparam int MEV_SRC_ASLEEP = 3;
   localparam int MEV_SRC_SHK = 0;
   localparam int MEV_RATE_LOWPWR = 4;
   localparam int MEV_FLG_SINGLE = 6;
   localparam int MEV_FLG_DOUBLE = 5;
   localparam int MEV_FLG_ACT = 4;
   localparam int MEV_FLG_INACT = 3;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] MEV_RST_ZERO = 8'h00;
   localparam logic [4:0] MEV_RST_RATE = 5'h0a;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int MEV_CLK_PERIOD_NS = 4;
   localparam int MEV_DUR_LSB_US = 625;
   localparam int MEV_WAIT_LSB_US = 1250;
   localparam int MEV_STILL_LSB_S = 1;
   localparam int MEV_TICK_CYC = (MEV_DUR_LSB_US * 1000) / MEV_CLK_PERIOD_NS;
   localparam int MEV_WAIT_TICKS = MEV_WAIT_LSB_US / MEV_DUR_LSB_US;
   localparam int MEV_STILL_TICKS = (MEV_STILL_LSB_S * 1000000) / MEV_DUR_LSB_US;

endpackage

//--- rtl/mev_detect.sv
// motion event detection: offset trim, shock, activity, inactivity,
// axis source and output rate registers
// assumes samples and register strokes come from logic on ref_clk_i
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - add signed per-axis trim to output samples
// - shock qualifies only if short enough
// - zero duration disables single and double shock
// - wait before second window; zero disables
// - second shock starts inside window; zero disables
// - activity compares against scaled motion threshold
// - inactivity compares against scaled stillness threshold
// - inactivity after stillness time, one-second steps
// - inactivity uses filtered data, others raw
// - need one sample; zero time fires at once
// - coupling bit selects dc or ac compare
// - ac activity compares against latched reference
// - ac inactivity refreshes reference when exceeded
// - axis enables; none enabled disables function
// - activity any axis, inactivity all axes
// - shock axis register layout, high bits zero
// - suppress cancels double on latency overshoot
// - source bits mark first axes, overwritten only
// - removed axis source clears at next event
// - asleep bit moves only under autosleep
// - rate register, low power bit, default 0x0a
// - shock compares against scaled shock threshold
// - event flags clear on reading them
module mev_detect
   import mev_pkg::*;
#(
   parameter int TICK_CYCLES = MEV_TICK_CYC,
   parameter int OFS_SHIFT = 2,
   parameter int THR_SHIFT = 4
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [5:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   input wire logic smp_valid_i,
   input wire logic [15:0] raw_x_i,
   input wire logic [15:0] raw_y_i,
   input wire logic [15:0] raw_z_i,
   input wire logic [15:0] filt_x_i,
   input wire logic [15:0] filt_y_i,
   input wire logic [15:0] filt_z_i,
   input wire logic autosleep_en_i,
   output logic [15:0] out_x_o,
   output logic [15:0] out_y_o,
   output logic [15:0] out_z_o,
   output logic [3:0] rate_code_o,
   output logic low_power_o,
   output logic asleep_o
);

   if (TICK_CYCLES < 1 || OFS_SHIFT < 0 || OFS_SHIFT > 7 || THR_SHIFT < 0 || THR_SHIFT > 8) begin : g_chk
      $error("mev_detect: parameter out of range");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SHK_IDLE,
      SHK_ABOVE,
      SHK_WAIT,
      SHK_WINDOW,
      SHK_ABOVE2,
      SHK_HOLD
   } mev_shk_t;

   typedef struct packed {
      logic [7:0] thr_shk;
      logic [2:0][7:0] trim;
      logic [7:0] shock_max_duration;
      logic [7:0] wait_t;
      logic [7:0] win;
      logic [7:0] thr_act;
      logic [7:0] thr_ina;
      logic [7:0] t_ina;
      logic [7:0] cpl;
      logic [3:0] shk_axes;
      logic [4:0] rate;
      logic [2:0] src_act;
      logic [2:0] src_shk;
      logic [3:0] flags;
      logic asleep;
      logic [31:0] tick_cnt;
      logic tick;
      mev_shk_t shk;
      logic [9:0] shk_cnt;
      logic [2:0] shk_lvl;
      logic [2:0] shk_first;
      logic [2:0][15:0] act_ref;
      logic act_ref_ok;
      logic [2:0][15:0] ina_ref;
      logic ina_seen;
      logic ina_below;
      logic [18:0] ina_cnt;
      logic ina_done;
      logic [2:0][15:0] outs;
      logic [7:0] rdata;
   } mev_state_t;

   mev_state_t q;
   mev_state_t d;
   logic act_evt;
   logic ina_evt;
   logic sgl_evt;
   logic dbl_evt;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // trim weight is a power of two of the data lsb; result saturates
   function automatic logic [15:0] mev_trim(input logic [15:0] s, input logic [7:0] t);
      logic signed [17:0] r;
      r = $signed({{2{s[15]}}, s}) + ($signed({{10{t[7]}}, t}) <<< OFS_SHIFT);
      if (r > 18'sh07fff) begin
         return 16'h7fff;
      end else if (r < -18'sh08000) begin
         return 16'h8000;
      end
      return r[15:0];
   endfunction

   // absolute difference of two signed samples
   function automatic logic [16:0] mev_mag(input logic [15:0] a, input logic [15:0] b);
      logic signed [16:0] dlt;
      dlt = $signed({a[15], a}) - $signed({b[15], b});
      return dlt[16] ? 17'(-dlt) : 17'(dlt);
   endfunction

   function automatic logic [16:0] mev_thr(input logic [7:0] t);
      return 17'({9'h000, t} << THR_SHIFT);
   endfunction

   logic [2:0][15:0] raw;
   logic [2:0][15:0] filt;
   // index 2 is x so axis vectors line up with the x y z enable and source bits
   assign raw = {raw_x_i, raw_y_i, raw_z_i};
   assign filt = {filt_x_i, filt_y_i, filt_z_i};

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [2:0] shk_over;
      logic [2:0] act_over;
      logic [2:0] ina_over;
      logic [2:0] act_ax;
      logic [2:0] ina_ax;
      logic [2:0] shk_ax;
      logic dbl_ok;
      logic rd_flags;
      d = q;
      shk_over = 3'h0;
      act_over = 3'h0;
      ina_over = 3'h0;
      act_ax = q.cpl[MEV_CPL_ACT_AX +: 3];
      ina_ax = q.cpl[MEV_CPL_INA_AX +: 3];
      shk_ax = q.shk_axes[2:0];
      dbl_ok = (q.wait_t != 8'h00) && (q.win != 8'h00);
      rd_flags = reg_rd_i && (reg_addr_i == MEV_OFS_EVT_FLAGS);
      act_evt = 1'b0;
      ina_evt = 1'b0;
      sgl_evt = 1'b0;
      dbl_evt = 1'b0;

      // event timers run from one shared timebase tick
      d.tick = 1'b0;
      if (q.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
         d.tick_cnt = 32'h0;
         d.tick = 1'b1;
      end else begin
         d.tick_cnt = q.tick_cnt + 32'h1;
      end

      for (int i = 0; i < 3; i++) begin
         shk_over[i] = mev_mag(raw[i], 16'h0000) > mev_thr(q.thr_shk);
         if (q.cpl[MEV_CPL_ACT_AC]) begin
            act_over[i] = mev_mag(raw[i], q.act_ref[i]) > mev_thr(q.thr_act);
         end else begin
            act_over[i] = mev_mag(raw[i], 16'h0000) > mev_thr(q.thr_act);
         end
         if (q.cpl[MEV_CPL_INA_AC]) begin
            ina_over[i] = mev_mag(filt[i], q.ina_ref[i]) >= mev_thr(q.thr_ina);
         end else begin
            ina_over[i] = mev_mag(filt[i], 16'h0000) >= mev_thr(q.thr_ina);
         end
      end

      // ------------------------------------------------------------
      // output samples and level capture
      // ------------------------------------------------------------
      if (smp_valid_i) begin
         for (int i = 0; i < 3; i++) begin
            d.outs[i] = mev_trim(raw[i], q.trim[i]);
         end
         d.shk_lvl = shk_over & shk_ax;
      end

      // ------------------------------------------------------------
      // activity: any enabled axis
      // ------------------------------------------------------------
      if (smp_valid_i && act_ax != 3'h0) begin
         if (q.cpl[MEV_CPL_ACT_AC] && !q.act_ref_ok) begin
            d.act_ref = raw;
            d.act_ref_ok = 1'b1;
         end else if ((act_over & act_ax) != 3'h0) begin
            act_evt = 1'b1;
            d.src_act = act_over & act_ax;
            d.act_ref_ok = 1'b0;
         end
      end
      if (!q.cpl[MEV_CPL_ACT_AC] || act_ax == 3'h0) begin
         d.act_ref_ok = 1'b0;
      end

      // ------------------------------------------------------------
      // inactivity: all enabled axes, filtered data
      // ------------------------------------------------------------
      if (ina_ax == 3'h0) begin
         d.ina_cnt = 19'h0;
         d.ina_done = 1'b0;
         d.ina_below = 1'b0;
      end else begin
         if (smp_valid_i) begin
            d.ina_seen = 1'b1;
            d.ina_below = (ina_over & ina_ax) == 3'h0;
            if ((ina_over & ina_ax) != 3'h0) begin
               d.ina_ref = filt;
               d.ina_cnt = 19'h0;
               d.ina_done = 1'b0;
            end
         end
         if (q.ina_seen && q.ina_below && !q.ina_done) begin
            if (q.ina_cnt >= 19'(32'(q.t_ina) * MEV_STILL_TICKS)) begin
               ina_evt = 1'b1;
               d.ina_done = 1'b1;
            end else if (q.tick) begin
               d.ina_cnt = q.ina_cnt + 19'h1;
            end
         end
      end

      // ------------------------------------------------------------
      // shock sequence
      // ------------------------------------------------------------
      case (q.shk)
         SHK_IDLE: begin
            if (q.shock_max_duration != 8'h00 && q.shk_lvl != 3'h0) begin
               d.shk = SHK_ABOVE;
               d.shk_cnt = 10'h0;
               d.shk_first = q.shk_lvl;
            end
         end
         SHK_ABOVE, SHK_ABOVE2: begin
            if (q.shk_cnt > {2'b00, q.shock_max_duration}) begin
               d.shk = SHK_HOLD;
            end else if (q.shk_lvl == 3'h0) begin
               d.src_shk = q.shk_first & shk_ax;
               d.shk_cnt = 10'h0;
               if (q.shk == SHK_ABOVE2) begin
                  dbl_evt = 1'b1;
                  d.shk = SHK_IDLE;
               end else begin
                  sgl_evt = 1'b1;
                  d.shk = dbl_ok ? SHK_WAIT : SHK_IDLE;
               end
            end else if (q.tick) begin
               d.shk_cnt = q.shk_cnt + 10'h1;
            end
         end
         SHK_WAIT: begin
            if (q.shk_axes[MEV_SHK_SUPPRESS] && q.shk_lvl != 3'h0) begin
               d.shk = SHK_IDLE;
            end else if (q.shk_cnt >= 10'(32'(q.wait_t) * MEV_WAIT_TICKS)) begin
               d.shk = SHK_WINDOW;
               d.shk_cnt = 10'h0;
            end else if (q.tick) begin
               d.shk_cnt = q.shk_cnt + 10'h1;
            end
         end
         SHK_WINDOW: begin
            if (q.shk_cnt >= 10'(32'(q.win) * MEV_WAIT_TICKS)) begin
               d.shk = SHK_IDLE;
            end else if (q.shk_lvl != 3'h0) begin
               d.shk = SHK_ABOVE2;
               d.shk_cnt = 10'h0;
               d.shk_first = q.shk_lvl;
            end else if (q.tick) begin
               d.shk_cnt = q.shk_cnt + 10'h1;
            end
         end
         SHK_HOLD: begin
            // an overlong shock must fall below threshold before a new one can start
            if (q.shk_lvl == 3'h0) begin
               d.shk = SHK_IDLE;
            end
         end
         default: begin
            d.shk = SHK_IDLE;
         end
      endcase
      if (q.shock_max_duration == 8'h00 || (!dbl_ok && q.shk != SHK_ABOVE && q.shk != SHK_IDLE)) begin
         d.shk = (q.shock_max_duration == 8'h00) ? SHK_IDLE : d.shk;
      end
      if (!dbl_ok && (q.shk == SHK_WAIT || q.shk == SHK_WINDOW || q.shk == SHK_ABOVE2)) begin
         d.shk = SHK_IDLE;
      end

      // only autosleep moves the asleep bit
      if (autosleep_en_i) begin
         if (ina_evt) begin
            d.asleep = 1'b1;
         end else if (act_evt) begin
            d.asleep = 1'b0;
         end
      end

      // ------------------------------------------------------------
      // register port; event flags clear on read, a new event wins
      // ------------------------------------------------------------
      if (rd_flags) begin
         d.flags = 4'h0;
      end
      d.flags = d.flags | {sgl_evt, dbl_evt, act_evt, ina_evt};

      if (reg_wr_i) begin
         case (reg_addr_i)
            MEV_OFS_SHOCK_THR: d.thr_shk = reg_wdata_i;
            MEV_OFS_X_TRIM: d.trim[2] = reg_wdata_i;
            MEV_OFS_Y_TRIM: d.trim[1] = reg_wdata_i;
            MEV_OFS_Z_TRIM: d.trim[0] = reg_wdata_i;
            MEV_OFS_DUR: d.shock_max_duration = reg_wdata_i;
            MEV_OFS_WAIT: d.wait_t = reg_wdata_i;
            MEV_OFS_WINDOW: d.win = reg_wdata_i;
            MEV_OFS_MOT_THR: d.thr_act = reg_wdata_i;
            MEV_OFS_STILL_THR: d.thr_ina = reg_wdata_i;
            MEV_OFS_STILL_TIME: d.t_ina = reg_wdata_i;
            MEV_OFS_COUPLING: d.cpl = reg_wdata_i;
            MEV_OFS_SHOCK_AXES: d.shk_axes = reg_wdata_i[3:0];
            MEV_OFS_RATE: d.rate = reg_wdata_i[4:0];
            default: begin
            end
         endcase
      end

      d.rdata = 8'h00;
      if (reg_rd_i) begin
         case (reg_addr_i)
            MEV_OFS_SHOCK_THR: d.rdata = q.thr_shk;
            MEV_OFS_X_TRIM: d.rdata = q.trim[2];
            MEV_OFS_Y_TRIM: d.rdata = q.trim[1];
            MEV_OFS_Z_TRIM: d.rdata = q.trim[0];
            MEV_OFS_DUR: d.rdata = q.shock_max_duration;
            MEV_OFS_WAIT: d.rdata = q.wait_t;
            MEV_OFS_WINDOW: d.rdata = q.win;
            MEV_OFS_MOT_THR: d.rdata = q.thr_act;
            MEV_OFS_STILL_THR: d.rdata = q.thr_ina;
            MEV_OFS_STILL_TIME: d.rdata = q.t_ina;
            MEV_OFS_COUPLING: d.rdata = q.cpl;
            MEV_OFS_SHOCK_AXES: d.rdata = {4'h0, q.shk_axes};
            MEV_OFS_SOURCE: d.rdata = {1'b0, q.src_act, q.asleep, q.src_shk};
            MEV_OFS_RATE: d.rdata = {3'h0, q.rate};
            MEV_OFS_EVT_FLAGS: d.rdata = {1'b0, q.flags, 3'h0};
            default: d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= '0;
         q.rate <= MEV_RST_RATE;
         q.shk <= SHK_IDLE;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata_o = q.rdata;
   assign out_x_o = q.outs[2];
   assign out_y_o = q.outs[1];
   assign out_z_o = q.outs[0];
   assign rate_code_o = q.rate[3:0];
   assign low_power_o = q.rate[MEV_RATE_LOWPWR];
   assign asleep_o = q.asleep;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   a_trim_output: assert property (smp_valid_i |=> out_x_o == mev_trim($past(raw_x_i), $past(q.trim[2])))
      else $error("trimmed sample mismatch");
   a_dur_zero_idle: assert property ((q.shock_max_duration == 8'h00) |=> q.shk == SHK_IDLE && !$past(sgl_evt))
      else $error("shock active with zero duration");
   a_wait_zero_nodbl: assert property ((q.wait_t == 8'h00) |-> !dbl_evt)
      else $error("double shock with zero wait");
   a_window_zero_nodbl: assert property ((q.win == 8'h00) |-> !dbl_evt)
      else $error("double shock with zero window");
   a_suppress_cancel: assert property ((q.shk == SHK_WAIT && q.shk_axes[MEV_SHK_SUPPRESS] && q.shk_lvl != 3'h0)
      |=> q.shk == SHK_IDLE)
      else $error("suppress did not cancel double shock");
   a_inact_needs_sample: assert property (ina_evt |-> q.ina_seen && q.cpl[2:0] != 3'h0)
      else $error("inactivity without sample or axes");
   a_act_axes_off: assert property ((q.cpl[6:4] == 3'h0) |-> !act_evt)
      else $error("activity with all axes off");
   a_flags_read_clear: assert property ((reg_rd_i && reg_addr_i == MEV_OFS_EVT_FLAGS && !act_evt && !ina_evt
      && !sgl_evt && !dbl_evt) |=> q.flags == 4'h0 && reg_rdata_o[6:3] == $past(q.flags))
      else $error("event flags not cleared by read");
   a_asleep_hold: assert property (!autosleep_en_i |=> $stable(asleep_o))
      else $error("asleep moved without autosleep");
   a_long_shock_drop: assert property ((q.shk == SHK_ABOVE && q.shk_cnt > {2'b00, q.shock_max_duration}) |=> q.shk == SHK_HOLD
      && !$past(sgl_evt))
      else $error("overlong shock qualified");

endmodule

`default_nettype wire

//--- testbench/mev_detect_tb.sv
// testbench of the motion event block: registers, trim, shock, motion and stillness detection
// assumes the design alone on ref_clk_i, with the timebase tick shortened to a few cycles
`timescale 1ns/10ps
`default_nettype none
module mev_detect_tb;
   import mev_pkg::*;
   localparam int TICK = 4;
   logic ref_clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic smp_valid_i = 1'b0, autosleep_en_i = 1'b0;
   logic [5:0] reg_addr_i = 6'h00;
   logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, d, tx, ty, tz;
   logic [15:0] raw_x_i = 16'h0000, raw_y_i = 16'h0000, raw_z_i = 16'h0000, rx, ry, rz;
   logic [15:0] filt_x_i = 16'h0000, filt_y_i = 16'h0000, filt_z_i = 16'h0000;
   logic [15:0] out_x_o, out_y_o, out_z_o;
   logic [3:0] rate_code_o;
   logic low_power_o, asleep_o;
   int failures = 0, tests_run = 0;
   logic [5:0] ra [0:12] = '{MEV_OFS_SHOCK_THR, MEV_OFS_X_TRIM, MEV_OFS_Y_TRIM, MEV_OFS_Z_TRIM, MEV_OFS_DUR,
      MEV_OFS_WAIT, MEV_OFS_WINDOW, MEV_OFS_MOT_THR, MEV_OFS_STILL_THR, MEV_OFS_STILL_TIME, MEV_OFS_COUPLING,
      MEV_OFS_SHOCK_AXES, MEV_OFS_RATE};
   logic [7:0] tv [0:12];
   logic [15:0] sv [0:2] = '{16'd1000, 16'd256, 16'hfeff};
   int dd [0:6] = '{28, 4, 70, 4, 4, 28, 28}, dx [0:6] = '{0, 0, 0, 20, 20, 0, 0};
   int dw [0:6] = '{3, 3, 3, 3, 3, 0, 3}, dn [0:6] = '{4, 4, 4, 4, 4, 4, 0};
   logic ds [0:6] = '{0, 0, 0, 0, 1, 0, 0}, de [0:6] = '{1, 0, 0, 1, 0, 0, 0};
   logic [7:0] ac [0:7] = '{8'h40, 8'h40, 8'h40, 8'h20, 8'h00, 8'hc0, 8'hc0, 8'hc0};
   logic [15:0] ax [0:7] = '{16'd257, 16'd256, 16'd0, 16'd0, 16'd1000, 16'd5000, 16'd5200, 16'd5300};
   logic [15:0] ay [0:7] = '{16'd0, 16'd0, 16'hfc18, 16'hfc18, 16'd1000, 16'd0, 16'd0, 16'd0};
   logic ae [0:7] = '{1, 0, 0, 1, 0, 0, 0, 1};
   logic [15:0] fy [0:3] = '{16'd2000, 16'd255, 16'd256, 16'hff01};
   logic ie [0:3] = '{0, 1, 0, 1};

   always #2 ref_clk_i = ~ref_clk_i;

   mev_detect #(.TICK_CYCLES(TICK)) uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .smp_valid_i(smp_valid_i), .raw_x_i(raw_x_i), .raw_y_i(raw_y_i), .raw_z_i(raw_z_i),
      .filt_x_i(filt_x_i), .filt_y_i(filt_y_i), .filt_z_i(filt_z_i), .autosleep_en_i(autosleep_en_i),
      .out_x_o(out_x_o), .out_y_o(out_y_o), .out_z_o(out_z_o), .rate_code_o(rate_code_o),
      .low_power_o(low_power_o), .asleep_o(asleep_o));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      cyc(1);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = v;
      cyc(1);
      reg_wr_i = 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] v);
      cyc(1);
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      cyc(1);
      reg_rd_i = 1'b0;
      v = reg_rdata_o;
   endtask
   // sample lines carry scrambled values outside the strobe so stale data never passes
   task automatic smp(input logic [15:0] x, y, z, fx, fyv, fz);
      cyc(1);
      smp_valid_i = 1'b1;
      {raw_x_i, raw_y_i, raw_z_i, filt_x_i, filt_y_i, filt_z_i} = {x, y, z, fx, fyv, fz};
      cyc(1);
      smp_valid_i = 1'b0;
      {raw_x_i, raw_y_i, raw_z_i, filt_x_i, filt_y_i, filt_z_i} = ~{x, y, z, fx, fyv, fz};
   endtask
   task automatic shock(input logic [15:0] x, y);
      smp(x, y, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      smp(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
   endtask
   function automatic logic [15:0] trim_exp(input logic [15:0] r, input logic [7:0] t);
      logic signed [17:0] s;
      s = $signed({{2{r[15]}}, r}) + $signed({{8{t[7]}}, t, 2'b00});
      if (s > 18'sd32767) return 16'h7fff;
      if (s < -18'sd32768) return 16'h8000;
      return s[15:0];
   endfunction

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      #200000;
      failures++;
      final_report();
   end
   initial begin
      void'($urandom(66941));
      repeat (6) @(posedge ref_clk_i);
      #1;
      nrst_i = 1'b1;
      chk("rate code", 16'h000a, rate_code_o);
      chk("asleep", 16'h0000, asleep_o);
      for (int i = 0; i < 13; i++) begin
         rd(ra[i], d);
         chk("reset value", (i == 12) ? {3'b000, MEV_RST_RATE} : MEV_RST_ZERO, d);
         tv[i] = 8'($urandom());
         wr(ra[i], tv[i]);
         rd(ra[i], d);
         chk("read back", tv[i] & ((i == 11) ? 8'h0f : (i == 12) ? 8'h1f : 8'hff), d);
      end
      chk("rate code", tv[12][3:0], rate_code_o);
      chk("low power", tv[12][4], low_power_o);
      wr(MEV_OFS_SOURCE, 8'hff);
      rd(MEV_OFS_SOURCE, d);
      chk("source read only", 16'h0000, d);
      wr(6'h28, 8'h55);
      rd(6'h28, d);
      chk("unmapped", 16'h0000, d);
      for (int i = 0; i < 13; i++) wr(ra[i], 8'h00);
      for (int i = 0; i < 10; i++) begin
         tx = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : 8'($urandom());
         rx = (i == 0) ? 16'h7ffe : (i == 1) ? 16'h8001 : 16'($urandom());
         ty = 8'($urandom());
         tz = 8'($urandom());
         ry = 16'($urandom());
         rz = 16'($urandom());
         wr(MEV_OFS_X_TRIM, tx);
         wr(MEV_OFS_Y_TRIM, ty);
         wr(MEV_OFS_Z_TRIM, tz);
         smp(rx, ry, rz, 16'h0000, 16'h0000, 16'h0000);
         chk("trim x", trim_exp(rx, tx), out_x_o);
         chk("trim y", trim_exp(ry, ty), out_y_o);
         chk("trim z", trim_exp(rz, tz), out_z_o);
      end
      for (int i = 1; i < 4; i++) wr(ra[i], 8'h00);
      // shock: threshold 16 counts of 16 lsb, duration 5 ticks
      wr(MEV_OFS_SHOCK_THR, 8'h10);
      wr(MEV_OFS_DUR, 8'h05);
      wr(MEV_OFS_SHOCK_AXES, 8'h04);
      rd(MEV_OFS_EVT_FLAGS, d);
      for (int i = 0; i < 3; i++) begin
         shock(sv[i], 16'h0000);
         rd(MEV_OFS_EVT_FLAGS, d);
         chk("single", ie[1] & (i != 1), d[MEV_FLG_SINGLE]);
         cyc(60);
      end
      rd(MEV_OFS_SOURCE, d);
      chk("shock source", 16'h0004, d[2:0]);
      smp(16'd1000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      cyc(100);
      shock(16'h0000, 16'h0000);
      rd(MEV_OFS_EVT_FLAGS, d);
      chk("long shock", 16'h0000, d[MEV_FLG_SINGLE]);
      wr(MEV_OFS_SHOCK_AXES, 8'h02);
      shock(16'd1000, 16'd1000);
      rd(MEV_OFS_SOURCE, d);
      chk("removed axis", 16'h0002, d[2:0]);
      cyc(60);
      for (int i = 0; i < 7; i++) begin
         wr(MEV_OFS_SHOCK_AXES, {4'h0, ds[i], 3'b100});
         wr(MEV_OFS_WAIT, 8'(dw[i]));
         wr(MEV_OFS_WINDOW, 8'(dn[i]));
         rd(MEV_OFS_EVT_FLAGS, d);
         shock(16'd1000, 16'h0000);
         cyc(dd[i]);
         shock(16'd1000, 16'h0000);
         if (dx[i] > 0) begin
            cyc(dx[i]);
            shock(16'd1000, 16'h0000);
         end
         rd(MEV_OFS_EVT_FLAGS, d);
         chk("double", de[i], d[MEV_FLG_DOUBLE]);
         cyc(60);
      end
      wr(MEV_OFS_DUR, 8'h00);
      shock(16'd1000, 16'h0000);
      rd(MEV_OFS_EVT_FLAGS, d);
      chk("zero duration", 16'h0000, d[MEV_FLG_SINGLE]);
      wr(MEV_OFS_SHOCK_AXES, 8'h00);
      wr(MEV_OFS_MOT_THR, 8'h10);
      for (int i = 0; i < 8; i++) begin
         if (i == 0 || ac[i] != ac[i-1]) wr(MEV_OFS_COUPLING, ac[i]);
         rd(MEV_OFS_EVT_FLAGS, d);
         smp(ax[i], ay[i], 16'h0000, 16'h0000, 16'h0000, 16'h0000);
         rd(MEV_OFS_EVT_FLAGS, d);
         chk("activity", ae[i], d[MEV_FLG_ACT]);
         if (i == 3) rd(MEV_OFS_SOURCE, d);
         if (i == 3) chk("activity source", 16'h0002, d[6:4]);
      end
      // stillness: dc, all axes, zero time
      wr(MEV_OFS_COUPLING, 8'h07);
      wr(MEV_OFS_STILL_THR, 8'h10);
      for (int i = 0; i < 4; i++) begin
         autosleep_en_i = (i > 1);
         smp(16'd5000, 16'h0000, 16'h0000, 16'd100, fy[i], 16'h0000);
         cyc(2);
         rd(MEV_OFS_EVT_FLAGS, d);
         chk("stillness", ie[i], d[MEV_FLG_INACT]);
         chk("asleep", i == 3, asleep_o);
         rd(MEV_OFS_EVT_FLAGS, d);
         chk("flags cleared", 16'h0000, d[MEV_FLG_INACT]);
      end
      rd(MEV_OFS_SOURCE, d);
      chk("asleep bit", 16'h0001, d[MEV_SRC_ASLEEP]);
      wr(MEV_OFS_COUPLING, 8'h47);
      smp(16'd5000, 16'h0000, 16'h0000, 16'd100, 16'd100, 16'h0000);
      rd(MEV_OFS_EVT_FLAGS, d);
      chk("wake activity", 16'h0001, d[MEV_FLG_ACT]);
      chk("awake", 16'h0000, asleep_o);
      // one second of stillness is 1600 ticks of TICK cycles
      wr(MEV_OFS_COUPLING, 8'h07);
      wr(MEV_OFS_STILL_TIME, 8'h01);
      smp(16'h0000, 16'h0000, 16'h0000, 16'd100, 16'd2000, 16'h0000);
      smp(16'h0000, 16'h0000, 16'h0000, 16'd100, 16'd100, 16'h0000);
      cyc(1500 * TICK);
      rd(MEV_OFS_EVT_FLAGS, d);
      chk("still early", 16'h0000, d[MEV_FLG_INACT]);
      cyc(150 * TICK);
      rd(MEV_OFS_EVT_FLAGS, d);
      chk("still timed", 16'h0001, d[MEV_FLG_INACT]);
      chk("asleep again", 16'h0001, asleep_o);
      final_report();
   end
endmodule
`default_nettype wire
